//--- hw/qsh_pkg.sv
package qsh_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned NGRP = 4;
  localparam int unsigned NREG = 5;

  // Group indices
  localparam logic [1:0] GRP_TOP = 2'h0;
  localparam logic [1:0] GRP_FREQ = 2'h1;
  localparam logic [1:0] GRP_MOD = 2'h2;
  localparam logic [1:0] GRP_PWR = 2'h3;

  // Register kind within a group
  localparam logic [2:0] KIND_COND = 3'h0;
  localparam logic [2:0] KIND_EVENT = 3'h1;
  localparam logic [2:0] KIND_ENABLE = 3'h2;
  localparam logic [2:0] KIND_PTR = 3'h3;
  localparam logic [2:0] KIND_NTR = 3'h4;

  // Byte address layout: group in [6:5], kind in [4:2]
  localparam int unsigned ADDR_KIND_LSB = 2;
  localparam int unsigned ADDR_GRP_LSB = 5;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h080;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h084;
  localparam logic [11:0] ADDR_PRESET = 12'h088;
  localparam logic [11:0] ADDR_STB = 12'h08c;

  // Summary and condition bit positions
  localparam int unsigned BIT_PWR_SUM = 3;
  localparam int unsigned BIT_OVEN_COLD = 4;
  localparam int unsigned BIT_FREQ_SUM = 5;
  localparam int unsigned BIT_MOD_SUM = 7;
  localparam int unsigned BIT_STB_QUES = 3;
  localparam int unsigned BIT_REF_UNLOCK = 2;
  localparam int unsigned BIT_UNLEVELED = 1;
  localparam int unsigned BIT_UNDERMOD = 0;

  // Preset values
  localparam logic [15:0] PRESET_PTR = 16'hffff;
  localparam logic [15:0] PRESET_NTR = 16'h0000;
  localparam logic [15:0] PRESET_ENABLE = 16'h0000;
  localparam logic [3:0] IRQ_ZERO = 4'h0;

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] event_bits;
    logic [15:0] enable;
    logic [15:0] ptr;
    logic [15:0] ntr;
  } qsh_grp_type;

  typedef struct packed {
    qsh_grp_type [3:0] grp;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [31:0] prdata;
  } qsh_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } qsh_apb_req_type;

endpackage

//--- hw/qsh_status.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
module qsh_status import qsh_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Live condition sources
  input wire logic [15:0] top_cond_src,
  input wire logic [15:0] freq_cond_src,
  input wire logic [15:0] mod_cond_src,
  input wire logic [15:0] pwr_cond_src,
  input wire logic oven_cold,
  input wire logic ref_unlocked,
  input wire logic rf_unleveled,
  input wire logic ext1_undermod,
  // Summaries
  output logic [7:0] status_byte,
  output logic [3:0] group_summary,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  qsh_state_type st;
  qsh_state_type next_st;
  logic [15:0] cond [NGRP];
  logic [3:0] summ;
  logic acc;
  logic [1:0] a_grp;
  logic [2:0] a_kind;
  logic a_hit;
  logic [15:0] edge_bits [NGRP];
  logic rd_setup;
  logic rd_acc;

  function automatic logic summary_of(input logic [15:0] ev, input logic [15:0] en);
    summary_of = |(ev & en);
  endfunction

  function automatic logic [15:0] edges_of(input logic [15:0] now, input logic [15:0] was,
                                          input logic [15:0] p, input logic [15:0] n);
    edges_of = (now & ~was & p) | (~now & was & n);
  endfunction

  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      summ[g] = summary_of(st.grp[g].event_bits, st.grp[g].enable);
    end
  end

  // Filtered transitions of every group
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      edge_bits[g] = edges_of(cond[g], st.grp[g].prev, st.grp[g].ptr, st.grp[g].ntr);
    end
  end

  // Live condition assembly
  always_comb begin
    cond[GRP_FREQ] = freq_cond_src;
    cond[GRP_FREQ][BIT_REF_UNLOCK] = ref_unlocked;
    cond[GRP_MOD] = mod_cond_src;
    cond[GRP_MOD][BIT_UNDERMOD] = ext1_undermod;
    cond[GRP_PWR] = pwr_cond_src;
    cond[GRP_PWR][BIT_UNLEVELED] = rf_unleveled;
    cond[GRP_TOP] = top_cond_src;
    cond[GRP_TOP][BIT_PWR_SUM] = summ[GRP_PWR];
    cond[GRP_TOP][BIT_OVEN_COLD] = oven_cold;
    cond[GRP_TOP][BIT_FREQ_SUM] = summ[GRP_FREQ];
    cond[GRP_TOP][BIT_MOD_SUM] = summ[GRP_MOD];
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign acc = psel & penable;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_acc = acc & ~pwrite;
  assign a_grp = paddr[ADDR_GRP_LSB +: 2];
  assign a_kind = paddr[ADDR_KIND_LSB +: 3];
  assign a_hit = (paddr[11:ADDR_GRP_LSB + 2] == '0) && (a_kind < 3'(NREG))
                 && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  assign pslverr = acc & ~a_hit & (paddr != ADDR_IRQ_STATUS) & (paddr != ADDR_IRQ_MASK)
                   & (paddr != ADDR_PRESET) & (paddr != ADDR_STB);

  always_comb begin
    logic [15:0] rd;
    logic [3:0] irq_set;
    rd = '0;
    irq_set = '0;
    next_st = st;
    // Read data captured in setup so it stands at the completing edge
    if (rd_setup) begin
      if (a_hit) begin
        case (a_kind)
          KIND_COND: rd = cond[a_grp];
          KIND_EVENT: rd = st.grp[a_grp].event_bits;
          KIND_ENABLE: rd = st.grp[a_grp].enable;
          KIND_PTR: rd = st.grp[a_grp].ptr;
          KIND_NTR: rd = st.grp[a_grp].ntr;
          default: rd = '0;
        endcase
      end else if (paddr == ADDR_IRQ_STATUS) begin
        rd = {12'h000, st.irq_status};
      end else if (paddr == ADDR_IRQ_MASK) begin
        rd = {12'h000, st.irq_mask};
      end else if (paddr == ADDR_STB) begin
        rd = {8'h00, status_byte};
      end
      next_st.prdata = {16'h0000, rd};
    end
    for (int g = 0; g < NGRP; g++) begin
      next_st.grp[g].prev = cond[g];
      irq_set[g] = |edge_bits[g];
      if (rd_acc && a_hit && a_kind == KIND_EVENT && a_grp == 2'(g)) begin
        // Only the bits handed out are cleared; a new edge wins
        next_st.grp[g].event_bits = (st.grp[g].event_bits & ~st.prdata[15:0])
                                    | edge_bits[g];
      end else begin
        next_st.grp[g].event_bits = st.grp[g].event_bits | edge_bits[g];
      end
      if (acc && pwrite && a_hit && a_grp == 2'(g)) begin
        case (a_kind)
          KIND_ENABLE: next_st.grp[g].enable = pwdata[15:0];
          KIND_PTR: next_st.grp[g].ptr = pwdata[15:0];
          KIND_NTR: next_st.grp[g].ntr = pwdata[15:0];
          default: ;
        endcase
      end
      if (acc && pwrite && paddr == ADDR_PRESET) begin
        next_st.grp[g].enable = PRESET_ENABLE;
        next_st.grp[g].ptr = PRESET_PTR;
        next_st.grp[g].ntr = PRESET_NTR;
      end
    end
    // Sticky interrupt status: set wins over read-clear
    if (acc && !pwrite && paddr == ADDR_IRQ_STATUS) begin
      next_st.irq_status = (st.irq_status & ~st.prdata[3:0]) | irq_set;
    end else begin
      next_st.irq_status = st.irq_status | irq_set;
    end
    if (acc && pwrite && paddr == ADDR_IRQ_MASK) begin
      next_st.irq_mask = pwdata[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < NGRP; g++) begin
        st.grp[g].prev <= '0;
        st.grp[g].event_bits <= '0;
        st.grp[g].enable <= PRESET_ENABLE;
        st.grp[g].ptr <= PRESET_PTR;
        st.grp[g].ntr <= PRESET_NTR;
      end
      st.irq_status <= IRQ_ZERO;
      st.irq_mask <= IRQ_ZERO;
      st.prdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign prdata = st.prdata;
  assign group_summary = summ;
  always_comb begin
    status_byte = 8'h00;
    status_byte[BIT_STB_QUES] = summ[GRP_TOP];
  end
  assign irq = |(st.irq_status & st.irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_rise(int g, int b);
    !st.grp[g].prev[b] ##1 st.grp[g].prev[b];
  endsequence

  sequence s_fall(int g, int b);
    st.grp[g].prev[b] ##1 !st.grp[g].prev[b];
  endsequence

  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence

  sequence s_rd_access;
    psel && penable && !pwrite;
  endsequence

  sequence s_rd_pair;
    s_rd_setup ##1 s_rd_access;
  endsequence

  sequence s_wr_kind(logic [2:0] k);
    psel && penable && pwrite && a_hit && a_kind == k;
  endsequence

  a_rise_sets_event: assert property (@(posedge mclk) disable iff (!rst_n)
    (cond[GRP_PWR][BIT_UNLEVELED] && !st.grp[GRP_PWR].prev[BIT_UNLEVELED]
     && st.grp[GRP_PWR].ptr[BIT_UNLEVELED])
    |=> st.grp[GRP_PWR].event_bits[BIT_UNLEVELED])
    else $error("rising edge lost");

  a_fall_sets_event: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cond[GRP_FREQ][BIT_REF_UNLOCK] && st.grp[GRP_FREQ].prev[BIT_REF_UNLOCK]
     && st.grp[GRP_FREQ].ntr[BIT_REF_UNLOCK])
    |=> st.grp[GRP_FREQ].event_bits[BIT_REF_UNLOCK])
    else $error("falling edge lost");

  a_filter_blocks: assert property (@(posedge mclk) disable iff (!rst_n)
    (!st.grp[GRP_MOD].event_bits[BIT_UNDERMOD] && !st.grp[GRP_MOD].ptr[BIT_UNDERMOD]
     && !st.grp[GRP_MOD].ntr[BIT_UNDERMOD])
    |=> !st.grp[GRP_MOD].event_bits[BIT_UNDERMOD])
    else $error("event set without filter");

  a_event_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    (st.grp[GRP_TOP].event_bits[BIT_OVEN_COLD] && !(acc && !pwrite))
    |=> st.grp[GRP_TOP].event_bits[BIT_OVEN_COLD])
    else $error("event bit dropped");

  a_read_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_access ##0 (a_hit && a_kind == KIND_EVENT && a_grp == GRP_PWR)
    |=> (st.grp[GRP_PWR].event_bits & $past(st.prdata[15:0])
         & ~$past(edge_bits[GRP_PWR])) == 16'h0000)
    else $error("event read clear wrong");

  a_summary_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    group_summary[GRP_FREQ] == |(st.grp[GRP_FREQ].event_bits & st.grp[GRP_FREQ].enable))
    else $error("frequency summary wrong");

  a_top_links: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_TOP][BIT_FREQ_SUM] == group_summary[GRP_FREQ]
    && cond[GRP_TOP][BIT_MOD_SUM] == group_summary[GRP_MOD]
    && cond[GRP_TOP][BIT_PWR_SUM] == group_summary[GRP_PWR])
    else $error("summary link wrong");

  a_stb_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    status_byte[BIT_STB_QUES] == |(st.grp[GRP_TOP].event_bits & st.grp[GRP_TOP].enable))
    else $error("status byte bit wrong");

  a_preset_apply: assert property (@(posedge mclk) disable iff (!rst_n)
    (acc && pwrite && paddr == ADDR_PRESET)
    |=> st.grp[GRP_MOD].ptr == PRESET_PTR && st.grp[GRP_MOD].ntr == PRESET_NTR
        && st.grp[GRP_MOD].enable == PRESET_ENABLE)
    else $error("preset not applied");

  a_preset_others: assert property (@(posedge mclk) disable iff (!rst_n)
    (acc && pwrite && paddr == ADDR_PRESET)
    |=> st.grp[GRP_TOP].ptr == PRESET_PTR && st.grp[GRP_FREQ].ntr == PRESET_NTR
        && st.grp[GRP_PWR].enable == PRESET_ENABLE)
    else $error("preset missed a group");

  ////////////////////////////////////////////////////////////////////////
  // Transition, bus and link checks
  a_rise_latched: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rise(GRP_PWR, BIT_UNLEVELED) ##0 $past(st.grp[GRP_PWR].ptr[BIT_UNLEVELED])
    |-> st.grp[GRP_PWR].event_bits[BIT_UNLEVELED])
    else $error("power rise not latched");

  a_fall_latched: assert property (@(posedge mclk) disable iff (!rst_n)
    s_fall(GRP_FREQ, BIT_REF_UNLOCK) ##0 $past(st.grp[GRP_FREQ].ntr[BIT_REF_UNLOCK])
    |-> st.grp[GRP_FREQ].event_bits[BIT_REF_UNLOCK])
    else $error("frequency fall not latched");

  a_read_data_held: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_pair |=> $stable(prdata))
    else $error("read data moved during access");

  a_cond_read: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_setup ##0 (a_hit && a_kind == KIND_COND)
    |=> prdata == {16'h0000, $past(cond[a_grp])})
    else $error("condition read wrong");

  a_event_read: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_setup ##0 (a_hit && a_kind == KIND_EVENT && a_grp == GRP_FREQ)
    |=> prdata == {16'h0000, $past(st.grp[GRP_FREQ].event_bits)})
    else $error("event read value wrong");

  a_ptr_read: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_setup ##0 (a_hit && a_kind == KIND_PTR && a_grp == GRP_MOD)
    |=> prdata == {16'h0000, $past(st.grp[GRP_MOD].ptr)})
    else $error("filter read value wrong");

  a_cond_no_side: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_access ##0 (a_hit && a_kind == KIND_COND)
    |=> st.grp[GRP_FREQ].event_bits
        == ($past(st.grp[GRP_FREQ].event_bits) | $past(edge_bits[GRP_FREQ])))
    else $error("condition read had a side effect");

  a_irq_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_access ##0 (paddr == ADDR_IRQ_STATUS) ##1 st.irq_status[GRP_FREQ]
    |-> $past(st.prdata[GRP_FREQ]) == 1'b0 || $past(|edge_bits[GRP_FREQ]))
    else $error("interrupt status not cleared");

  a_ptr_write: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_kind(KIND_PTR) |=> st.grp[$past(a_grp)].ptr == $past(pwdata[15:0]))
    else $error("positive filter write lost");

  a_ntr_write: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_kind(KIND_NTR) |=> st.grp[$past(a_grp)].ntr == $past(pwdata[15:0]))
    else $error("negative filter write lost");

  a_enable_write: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_kind(KIND_ENABLE) |=> st.grp[$past(a_grp)].enable == $past(pwdata[15:0]))
    else $error("enable write lost");

  a_mod_summary: assert property (@(posedge mclk) disable iff (!rst_n)
    group_summary[GRP_MOD] == |(st.grp[GRP_MOD].event_bits & st.grp[GRP_MOD].enable))
    else $error("modulation summary wrong");

  a_pwr_summary: assert property (@(posedge mclk) disable iff (!rst_n)
    group_summary[GRP_PWR] == |(st.grp[GRP_PWR].event_bits & st.grp[GRP_PWR].enable))
    else $error("power summary wrong");

  a_top_summary: assert property (@(posedge mclk) disable iff (!rst_n)
    group_summary[GRP_TOP] == |(st.grp[GRP_TOP].event_bits & st.grp[GRP_TOP].enable))
    else $error("top summary wrong");

  a_mod_link: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_TOP][BIT_MOD_SUM] == group_summary[GRP_MOD])
    else $error("modulation link wrong");

  a_pwr_link: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_TOP][BIT_PWR_SUM] == group_summary[GRP_PWR])
    else $error("power link wrong");

  a_oven_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_TOP][BIT_OVEN_COLD] == oven_cold)
    else $error("oven bit wrong");

  a_ref_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_FREQ][BIT_REF_UNLOCK] == ref_unlocked)
    else $error("reference bit wrong");

  a_level_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_PWR][BIT_UNLEVELED] == rf_unleveled)
    else $error("unleveled bit wrong");

  a_undermod_bit: assert property (@(posedge mclk) disable iff (!rst_n)
    cond[GRP_MOD][BIT_UNDERMOD] == ext1_undermod)
    else $error("undermod bit wrong");

  a_prev_tracks: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> st.grp[GRP_MOD].prev == $past(cond[GRP_MOD]))
    else $error("previous condition wrong");

  a_stb_spare: assert property (@(posedge mclk) disable iff (!rst_n)
    (status_byte & ~(8'h01 << BIT_STB_QUES)) == 8'h00)
    else $error("status byte spare bit set");

endmodule

//--- sim/qsh_status_tb_top.sv
module qsh_status_tb_top import qsh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] top_cond_src = 16'h0;
  logic [15:0] freq_cond_src = 16'h0;
  logic [15:0] mod_cond_src = 16'h0;
  logic [15:0] pwr_cond_src = 16'h0;
  logic oven_cold = 1'b0;
  logic ref_unlocked = 1'b0;
  logic rf_unleveled = 1'b0;
  logic ext1_undermod = 1'b0;
  logic [7:0] status_byte;
  logic [3:0] group_summary;
  logic irq;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #12.5 mclk = ~mclk;

  qsh_status qsh_status_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .top_cond_src(top_cond_src), .freq_cond_src(freq_cond_src),
    .mod_cond_src(mod_cond_src), .pwr_cond_src(pwr_cond_src), .oven_cold(oven_cold),
    .ref_unlocked(ref_unlocked), .rf_unleveled(rf_unleveled), .ext1_undermod(ext1_undermod),
    .status_byte(status_byte), .group_summary(group_summary), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("BAD %0t run timed out", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ad(input logic [1:0] g, input logic [2:0] k);
    return {5'h0, g, k, 2'h0};
  endfunction

  // Read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    e = pslverr;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    for (int g = 0; g < 4; g++) begin
      rc(ad(g[1:0], KIND_PTR), 32'h0000ffff);
      rc(ad(g[1:0], KIND_NTR), 32'h0);
      rc(ad(g[1:0], KIND_ENABLE), 32'h0);
      wr(ad(g[1:0], KIND_PTR), 32'h0001a5c3);
      rc(ad(g[1:0], KIND_PTR), 32'h0000a5c3);
      wr(ad(g[1:0], KIND_NTR), 32'h5a3c);
      wr(ad(g[1:0], KIND_ENABLE), 32'h0f0f);
    end
    wr(ADDR_PRESET, 32'h1);
    for (int g = 0; g < 4; g++) begin
      rc(ad(g[1:0], KIND_PTR), {16'h0, PRESET_PTR});
      rc(ad(g[1:0], KIND_NTR), {16'h0, PRESET_NTR});
      rc(ad(g[1:0], KIND_ENABLE), {16'h0, PRESET_ENABLE});
    end
    apb(1'b0, 12'h0a0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask

  task automatic t_edges;
    wr(ad(GRP_FREQ, KIND_PTR), 32'h0004);
    wr(ad(GRP_FREQ, KIND_NTR), 32'h0008);
    freq_cond_src <= 16'h0001;
    ref_unlocked <= 1'b1;
    oven_cold <= 1'b1;
    repeat (2) @(posedge mclk);
    rc(ad(GRP_FREQ, KIND_COND), 32'h5);
    rc(ad(GRP_FREQ, KIND_COND), 32'h5);
    rc(ad(GRP_TOP, KIND_COND), 32'h10);
    rc(ad(GRP_FREQ, KIND_EVENT), 32'h4);
    rc(ad(GRP_FREQ, KIND_EVENT), 32'h0);
    freq_cond_src <= 16'h0008;
    repeat (2) @(posedge mclk);
    freq_cond_src <= 16'h0;
    ref_unlocked <= 1'b0;
    oven_cold <= 1'b0;
    repeat (6) @(posedge mclk);
    rc(ad(GRP_FREQ, KIND_EVENT), 32'h8);
    rc(ad(GRP_TOP, KIND_EVENT), 32'h10);
  endtask

  task automatic t_summary;
    logic [1:0] gs[3] = '{GRP_FREQ, GRP_MOD, GRP_PWR};
    int sb[3] = '{BIT_REF_UNLOCK, BIT_UNDERMOD, BIT_UNLEVELED};
    int tb[3] = '{BIT_FREQ_SUM, BIT_MOD_SUM, BIT_PWR_SUM};
    logic [31:0] m;
    logic [31:0] t;
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 3; i++) begin
      m = 32'h1 << sb[i];
      t = 32'h1 << tb[i];
      apb(1'b0, ADDR_IRQ_STATUS, 32'h0, r, e);
      wr(ADDR_IRQ_MASK, 32'h0);
      {rf_unleveled, ext1_undermod, ref_unlocked} <= 3'b001 << i;
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h1 << gs[i]);
      chk({31'h0, irq}, 32'h1);
      rc(ADDR_IRQ_STATUS, 32'h1 << gs[i]);
      chk({31'h0, irq}, 32'h0);
      wr(ad(gs[i], KIND_ENABLE), ~m & 32'hffff);
      chk({31'h0, group_summary[gs[i]]}, 32'h0);
      wr(ad(gs[i], KIND_ENABLE), m);
      chk({31'h0, group_summary[gs[i]]}, 32'h1);
      rc(ad(GRP_TOP, KIND_COND), t);
      wr(ad(GRP_TOP, KIND_ENABLE), t);
      chk({24'h0, status_byte}, 32'h8);
      rc(ad(gs[i], KIND_EVENT), m);
      chk({31'h0, group_summary[gs[i]]}, 32'h0);
      rc(ad(GRP_TOP, KIND_EVENT), t);
      chk({24'h0, status_byte}, 32'h0);
      {rf_unleveled, ext1_undermod, ref_unlocked} <= 3'b000;
      wr(ad(gs[i], KIND_ENABLE), 32'h0);
      wr(ad(GRP_TOP, KIND_ENABLE), 32'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_edges();
    t_summary();
    end_sim();
  end
endmodule
